/* File: rafe_exec.sv */
// Purpose: Executes the rotate-right-no-carry and fill-ones byte instructions
// Assumes: Instructions arrive as 16-bit words written over AXI4-Lite
// Notes:   Four cycles per instruction, one per phase of the instruction cycle
//
// Contract
// - Rotate right, bit0 to bit7, N/Z only
// - Rotate destination bit one: file, zero: working register; fill always writes file
// - Fill writes FFh, flags untouched
// - Access bit zero selects the access bank
// - Access bit one uses bank pointer
// - Extended set, f<=95: indexed literal offset
`timescale 1ns/1ps

module rafe_exec #(
    parameter int MEM_DEPTH = 4096
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire rafe_pkg::rafe_axi_req_t axi_req,
    output rafe_pkg::rafe_axi_rsp_t      axi_rsp
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic reg_mapped(input logic [7:0] addr);
        case (addr)
            rafe_pkg::OFS_CTRL, rafe_pkg::OFS_BANK, rafe_pkg::OFS_WREG,
            rafe_pkg::OFS_INDEX, rafe_pkg::OFS_INSTR, rafe_pkg::OFS_STATUS,
            rafe_pkg::OFS_MADDR, rafe_pkg::OFS_MDATA: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [11:0] data_addr(input logic        acc,
                                              input logic [7:0]  f,
                                              input logic [3:0]  bank,
                                              input logic        ext,
                                              input logic [11:0] base);
        logic [11:0] res;
        res = 12'h000;
        if (acc) begin
            res = {bank, f};
        end else if (ext && (f <= rafe_pkg::ILO_LIMIT)) begin
            res = 12'(base + {4'h0, f});
        end else if (f < rafe_pkg::ACC_SPLIT) begin
            res = {4'h0, f};
        end else begin
            res = {rafe_pkg::ACC_HIGH_BANK, f};
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------------
    function automatic logic rot_word(input logic [15:0] word);
        return (word[15:10] == rafe_pkg::OPC_ROT);
    endfunction

    function automatic logic fill_word(input logic [15:0] word);
        return (word[15:9] == rafe_pkg::OPC_FILL);
    endfunction

    // ------------------------------------------------------------------
    // State and data memory
    // ------------------------------------------------------------------
    rafe_pkg::rafe_state_t s_r;
    rafe_pkg::rafe_state_t s_nxt;
    logic [7:0]            mem [MEM_DEPTH];
    logic                  mem_we;
    logic [11:0]           mem_wa;
    logic [7:0]            mem_wd;

    assign axi_rsp = s_r.rsp;

    always_comb begin
        logic [31:0] old_v;
        logic [31:0] new_v;
        logic [31:0] rd;
        logic        do_wr;
        logic        busy;
        logic        dest_bit;
        logic        acc_bit;
        logic [7:0]  file_sel;
        old_v  = 32'h0000_0000;
        new_v  = 32'h0000_0000;
        rd     = 32'h0000_0000;
        do_wr  = 1'b0;
        busy   = (s_r.phase != rafe_pkg::PH_IDLE);
        s_nxt  = s_r;
        mem_we = 1'b0;
        mem_wa = 12'h000;
        mem_wd = 8'h00;

        // --------------------------------------------------------------
        // Instruction fields
        // --------------------------------------------------------------
        dest_bit = s_r.instr[rafe_pkg::INS_DEST_BIT];
        acc_bit  = s_r.instr[rafe_pkg::INS_ACC_BIT];
        file_sel = s_r.instr[7:0];

        // --------------------------------------------------------------
        // Write address and data capture, either order
        // --------------------------------------------------------------
        if (axi_req.awvalid && s_r.rsp.awready) begin
            s_nxt.aw_have     = 1'b1;
            s_nxt.aw_addr     = axi_req.awaddr;
            s_nxt.rsp.awready = 1'b0;
        end
        if (axi_req.wvalid && s_r.rsp.wready) begin
            s_nxt.w_have     = 1'b1;
            s_nxt.w_data     = axi_req.wdata;
            s_nxt.w_strb     = axi_req.wstrb;
            s_nxt.rsp.wready = 1'b0;
        end
        if (s_r.rsp.bvalid && axi_req.bready) begin
            s_nxt.rsp.bvalid  = 1'b0;
            s_nxt.rsp.awready = 1'b1;
            s_nxt.rsp.wready  = 1'b1;
        end
        do_wr = s_r.aw_have && s_r.w_have && !s_r.rsp.bvalid;

        // --------------------------------------------------------------
        // Instruction sequencing
        // --------------------------------------------------------------
        case (s_r.phase)
            rafe_pkg::PH_IDLE: begin
            end
            rafe_pkg::PH_Q1: begin
                s_nxt.is_rot    = rot_word(s_r.instr);
                s_nxt.dest_file = rot_word(s_r.instr) ? dest_bit : 1'b1;
                s_nxt.eaddr     = data_addr(acc_bit, file_sel,
                                            s_r.bank_pointer, s_r.ext_en,
                                            s_r.index_base);
                if (rot_word(s_r.instr) || fill_word(s_r.instr)) begin
                    s_nxt.phase = rafe_pkg::PH_Q2;
                end else begin
                    s_nxt.illegal = 1'b1;
                    s_nxt.done    = 1'b1;
                    s_nxt.phase   = rafe_pkg::PH_IDLE;
                end
            end
            rafe_pkg::PH_Q2: begin
                s_nxt.operand = mem[s_r.eaddr];
                s_nxt.phase   = rafe_pkg::PH_Q3;
            end
            rafe_pkg::PH_Q3: begin
                if (s_r.is_rot) begin
                    s_nxt.result = {s_r.operand[0], s_r.operand[7:1]};
                end else begin
                    s_nxt.result = rafe_pkg::FILL_VALUE;
                end
                s_nxt.phase = rafe_pkg::PH_Q4;
            end
            rafe_pkg::PH_Q4: begin
                if (s_r.dest_file) begin
                    mem_we = 1'b1;
                    mem_wa = s_r.eaddr;
                    mem_wd = s_r.result;
                end else begin
                    s_nxt.wreg = s_r.result;
                end
                if (s_r.is_rot) begin
                    s_nxt.neg  = s_r.result[7];
                    s_nxt.zero = (s_r.result == 8'h00);
                end
                s_nxt.done  = 1'b1;
                s_nxt.phase = rafe_pkg::PH_IDLE;
            end
            default: begin
                s_nxt.phase = rafe_pkg::PH_IDLE;
            end
        endcase

        // --------------------------------------------------------------
        // Register write
        // --------------------------------------------------------------
        if (do_wr) begin
            s_nxt.aw_have    = 1'b0;
            s_nxt.w_have     = 1'b0;
            s_nxt.rsp.bvalid = 1'b1;
            s_nxt.rsp.bresp  = reg_mapped(s_r.aw_addr) ? rafe_pkg::RESP_OKAY
                                                       : rafe_pkg::RESP_SLVERR;
            case (s_r.aw_addr)
                rafe_pkg::OFS_CTRL:  old_v = {31'h0000_0000, s_r.ext_en};
                rafe_pkg::OFS_BANK:  old_v = {28'h000_0000, s_r.bank_pointer};
                rafe_pkg::OFS_WREG:  old_v = {24'h00_0000, s_r.wreg};
                rafe_pkg::OFS_INDEX: old_v = {20'h0_0000, s_r.index_base};
                rafe_pkg::OFS_INSTR: old_v = {16'h0000, s_r.instr};
                rafe_pkg::OFS_MADDR: old_v = {20'h0_0000, s_r.maddr};
                rafe_pkg::OFS_MDATA: old_v = {24'h00_0000, mem[s_r.maddr]};
                default:             old_v = 32'h0000_0000;
            endcase
            new_v = merge_strb(old_v, s_r.w_data, s_r.w_strb);
            // Writes that would race the running instruction are dropped
            case (s_r.aw_addr)
                rafe_pkg::OFS_CTRL: begin
                    if (!busy) begin
                        s_nxt.ext_en = new_v[rafe_pkg::CTRL_EXT_BIT];
                    end
                end
                rafe_pkg::OFS_BANK: begin
                    if (!busy) begin
                        s_nxt.bank_pointer = new_v[3:0];
                    end
                end
                rafe_pkg::OFS_WREG: begin
                    if (!busy) begin
                        s_nxt.wreg = new_v[7:0];
                    end
                end
                rafe_pkg::OFS_INDEX: begin
                    if (!busy) begin
                        s_nxt.index_base = new_v[11:0];
                    end
                end
                rafe_pkg::OFS_INSTR: begin
                    if (!busy) begin
                        s_nxt.instr   = new_v[15:0];
                        s_nxt.phase   = rafe_pkg::PH_Q1;
                        s_nxt.done    = 1'b0;
                        s_nxt.illegal = 1'b0;
                    end
                end
                rafe_pkg::OFS_MADDR: begin
                    s_nxt.maddr = new_v[11:0];
                end
                rafe_pkg::OFS_MDATA: begin
                    if (!busy && s_r.w_strb[0]) begin
                        mem_we = 1'b1;
                        mem_wa = s_r.maddr;
                        mem_wd = new_v[7:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------------
        // Register read
        // --------------------------------------------------------------
        if (s_r.rsp.rvalid && axi_req.rready) begin
            s_nxt.rsp.rvalid  = 1'b0;
            s_nxt.rsp.arready = 1'b1;
        end
        if (axi_req.arvalid && s_r.rsp.arready) begin
            case (axi_req.araddr)
                rafe_pkg::OFS_CTRL:   rd = {31'h0000_0000, s_r.ext_en};
                rafe_pkg::OFS_BANK:   rd = {28'h000_0000, s_r.bank_pointer};
                rafe_pkg::OFS_WREG:   rd = {24'h00_0000, s_r.wreg};
                rafe_pkg::OFS_INDEX:  rd = {20'h0_0000, s_r.index_base};
                rafe_pkg::OFS_INSTR:  rd = {16'h0000, s_r.instr};
                rafe_pkg::OFS_MADDR:  rd = {20'h0_0000, s_r.maddr};
                rafe_pkg::OFS_MDATA:  rd = {24'h00_0000, mem[s_r.maddr]};
                rafe_pkg::OFS_STATUS: begin
                    rd[rafe_pkg::ST_BUSY_BIT] = busy;
                    rd[rafe_pkg::ST_NEG_BIT]  = s_r.neg;
                    rd[rafe_pkg::ST_ZERO_BIT] = s_r.zero;
                    rd[rafe_pkg::ST_ILL_BIT]  = s_r.illegal;
                    rd[rafe_pkg::ST_DONE_BIT] = s_r.done;
                end
                default:              rd = 32'h0000_0000;
            endcase
            s_nxt.rsp.arready = 1'b0;
            s_nxt.rsp.rvalid  = 1'b1;
            s_nxt.rsp.rdata   = rd;
            s_nxt.rsp.rresp   = reg_mapped(axi_req.araddr) ? rafe_pkg::RESP_OKAY
                                                           : rafe_pkg::RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= rafe_pkg::STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

endmodule // rafe_exec

/* File: rafe_pkg.sv */
// Purpose: Shared constants and types of the rotate and fill execution block
// Assumes: AXI4-Lite slave with 32-bit data, one clock, synchronous reset
// Notes:   Offsets are byte addresses of aligned 32-bit registers
package rafe_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_BANK   = 8'h04;
    localparam logic [7:0] OFS_WREG   = 8'h08;
    localparam logic [7:0] OFS_INDEX  = 8'h0c;
    localparam logic [7:0] OFS_INSTR  = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MADDR  = 8'h18;
    localparam logic [7:0] OFS_MDATA  = 8'h1c;

    // ------------------------------------------------------------------
    // Field positions and encodings
    // ------------------------------------------------------------------
    localparam int         CTRL_EXT_BIT  = 0;
    localparam int         ST_BUSY_BIT   = 0;
    localparam int         ST_NEG_BIT    = 1;
    localparam int         ST_ZERO_BIT   = 2;
    localparam int         ST_ILL_BIT    = 3;
    localparam int         ST_DONE_BIT   = 4;
    localparam int         INS_DEST_BIT  = 9;
    localparam int         INS_ACC_BIT   = 8;
    localparam logic [5:0] OPC_ROT       = 6'h10;
    localparam logic [6:0] OPC_FILL      = 7'h34;
    localparam logic [7:0] FILL_VALUE    = 8'hff;
    localparam logic [7:0] ILO_LIMIT     = 8'h5f;
    localparam logic [7:0] ACC_SPLIT     = 8'h60;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------------
    // Bus carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } rafe_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rafe_axi_rsp_t;

    // ------------------------------------------------------------------
    // Execution phases and module state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} rafe_phase_t;

    typedef struct packed {
        rafe_axi_rsp_t rsp;
        logic          aw_have;
        logic [7:0]    aw_addr;
        logic          w_have;
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        logic          ext_en;
        logic [3:0]    bank_pointer;
        logic [7:0]    wreg;
        logic [11:0]   index_base;
        logic [15:0]   instr;
        logic [11:0]   maddr;
        rafe_phase_t   phase;
        logic          is_rot;
        logic          dest_file;
        logic [11:0]   eaddr;
        logic [7:0]    operand;
        logic [7:0]    result;
        logic          neg;
        logic          zero;
        logic          illegal;
        logic          done;
    } rafe_state_t;

    localparam rafe_state_t STATE_RESET = '{
        rsp:     '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
        phase:   PH_IDLE,
        default: '0
    };

endpackage

/* File: rafe_asserts.sv */
// Purpose: Bus timing checks of the rotate and fill execution block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to rafe_exec, watches its ports only
`timescale 1ns/1ps

module rafe_asserts (
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire rafe_pkg::rafe_axi_req_t axi_req,
    input wire rafe_pkg::rafe_axi_rsp_t axi_rsp
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Write and read handshakes
    // ------------------------------------------------------------
    sequence s_wr_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_wr_answer;
        !axi_rsp.bvalid ##1 axi_rsp.bvalid;
    endsequence

    a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write response not two cycles after take");
    a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready
        |=> axi_rsp.rvalid && !axi_rsp.arready) else $error("read answer late");
    a_bresp_holds: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("bvalid dropped");
    a_rdata_holds: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("rvalid dropped");
    a_write_blocked: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write ready during response");
    a_ready_return: assert property (axi_rsp.bvalid && axi_req.bready
        |=> axi_rsp.awready && axi_rsp.wready && !axi_rsp.bvalid)
        else $error("write ready not restored");
    a_unmapped_read: assert property (axi_req.arvalid && axi_rsp.arready
        && axi_req.araddr > 8'h1c |=> axi_rsp.rresp == rafe_pkg::RESP_SLVERR
        && axi_rsp.rdata == 32'h0) else $error("unmapped read not refused");
    a_rdata_narrow: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:16] == 16'h0)
        else $error("upper read bits set");
endmodule // rafe_asserts

bind rafe_exec rafe_asserts u_chk (
    .clk    (clk),
    .rst_n  (rst_n),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp)
);

/* File: rafe_host.sv */
// Purpose: Bus master model driving the register port
// Assumes: Slave answers within 50 cycles
// Notes:   Released address and data lines show the inverse value
`timescale 1ns/1ps

module rafe_host (
    input  wire logic                    clk,
    input  wire rafe_pkg::rafe_axi_rsp_t axi_rsp,
    output rafe_pkg::rafe_axi_req_t      axi_req,
    output logic                         hung
);
    initial begin
        axi_req = '0;
        hung = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hf;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (axi_req.awvalid && axi_rsp.awready) begin
                axi_req.awvalid <= 1'b0;
                axi_req.awaddr <= ~a;
            end
            if (axi_req.wvalid && axi_rsp.wready) begin
                axi_req.wvalid <= 1'b0;
                axi_req.wdata <= ~d;
            end
        end while (!axi_rsp.bvalid && n < 50);
        r = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
        if (!axi_rsp.bvalid) hung <= 1'b1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (axi_req.arvalid && axi_rsp.arready) begin
                axi_req.arvalid <= 1'b0;
                axi_req.araddr <= ~a;
            end
        end while (!axi_rsp.rvalid && n < 50);
        d = axi_rsp.rdata;
        r = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
        if (!axi_rsp.rvalid) hung <= 1'b1;
    endtask
endmodule // rafe_host

/* File: tb_rotate_and_fill_exec.sv */
// Purpose: Self-checking bench of the rotate and fill execution block
// Assumes: Register map and opcodes of rafe_pkg
// Notes:   Bank pointer 3, index base 200h from the rotate cases on
`timescale 1ns/1ps

module tb_rotate_and_fill_exec;
    logic                    clk;
    logic                    rst_n;
    logic                    hung;
    logic                    stuck;
    rafe_pkg::rafe_axi_req_t axi_req;
    rafe_pkg::rafe_axi_rsp_t axi_rsp;
    logic [31:0]             rd_v;
    logic [1:0]              resp;
    int                      fails;
    int                      checked;
    logic [11:0]             fill_addr [5] = '{12'h020, 12'hf80, 12'h310, 12'h25f, 12'hf60};
    logic [8:0]              fill_af [5] = '{9'h020, 9'h080, 9'h110, 9'h05f, 9'h060};
    logic                    fill_ext [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    initial clk = 1'b0;
    always #5 clk = ~clk;

    rafe_exec #(.MEM_DEPTH(4096)) u_dut (
        .clk(clk), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp));
    rafe_host u_host (.clk(clk), .axi_rsp(axi_rsp), .axi_req(axi_req), .hung(hung));

    task automatic complete_run;
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        u_host.wr(a, d, resp);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        u_host.rd(a, rd_v, resp);
        chk(rd_v, exp);
    endtask

    task automatic setm(input logic [11:0] a, input logic [7:0] v);
        wreg(rafe_pkg::OFS_MADDR, {20'h0, a});
        wreg(rafe_pkg::OFS_MDATA, {24'h0, v});
    endtask

    // ------------------------------------------------------------
    // Start one instruction, poll until done
    // ------------------------------------------------------------
    task automatic exec(input logic [15:0] ins, input logic busy_exp);
        int n;
        n = 0;
        wreg(rafe_pkg::OFS_INSTR, {16'h0, ins});
        u_host.rd(rafe_pkg::OFS_STATUS, rd_v, resp);
        if (busy_exp) chk({31'h0, rd_v[0]}, 32'h1);
        while (rd_v[4] !== 1'b1 && n < 10) begin
            u_host.rd(rafe_pkg::OFS_STATUS, rd_v, resp);
            n++;
        end
        if (rd_v[4] !== 1'b1) begin
            stuck = 1'b1;
        end
    endtask

    task automatic rot_case(input logic d, input logic [7:0] v);
        logic [7:0] r;
        r = {v[0], v[7:1]};
        setm(12'h3a5, v);
        wreg(rafe_pkg::OFS_WREG, 32'h33);
        exec({6'h10, d, 1'b1, 8'ha5}, 1'b1);
        chk(rd_v, {27'h0, 1'b1, 1'b0, r == 8'h0, r[7], 1'b0});
        rchk(rafe_pkg::OFS_WREG, d ? 32'h33 : {24'h0, r});
        wreg(rafe_pkg::OFS_MADDR, 32'h3a5);
        rchk(rafe_pkg::OFS_MDATA, d ? r : v);
    endtask

    always @(posedge clk) begin
        if (hung || stuck) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        rst_n = 1'b0;
        stuck = 1'b0;
        fails = 0;
        checked = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 28; i += 4) rchk(8'(i), 32'h0);
        u_host.wr(8'h20, 32'h1, resp);
        chk({30'h0, resp}, {30'h0, rafe_pkg::RESP_SLVERR});
        rchk(8'h20, 32'h0);
        chk({30'h0, resp}, {30'h0, rafe_pkg::RESP_SLVERR});
        exec(16'hffff, 1'b0);
        chk(rd_v, 32'h18);
        wreg(rafe_pkg::OFS_BANK, 32'h3);
        wreg(rafe_pkg::OFS_INDEX, 32'h200);
        rot_case(1'b1, 8'h00);
        rot_case(1'b0, 8'hd7);
        rot_case(1'b1, 8'hd7);
        for (int i = 0; i < 5; i++) begin
            wreg(rafe_pkg::OFS_CTRL, {31'h0, fill_ext[i]});
            setm(fill_addr[i], 8'h5a);
            exec({7'h34, fill_af[i]}, 1'b1);
            chk(rd_v, 32'h12);
            wreg(rafe_pkg::OFS_MADDR, {20'h0, fill_addr[i]});
            rchk(rafe_pkg::OFS_MDATA, 32'hff);
        end
        complete_run();
    end
endmodule // tb_rotate_and_fill_exec
